// ### src/memory_pin_suspend_state_control.v
`timescale 1ns/10ps
`include "mem_pad_regs.vh"

// How it works
// - with strobe refresh in suspend the row and column strobes keep toggling.
// - with self-refresh in suspend every enabled row and column strobe is held low.
// - with dram power-down in suspend strobes and write strobe float with pulldowns.
// - shared upper-bank strobes follow dram suspend only when enabled as strobes.
// - with dram left powered the write strobe is driven high through suspend.
// - lower sixteen data lines have pulldowns while inputs, none while driven.
// - in suspend the top row-address line floats with its pulldown on.
// - the lowest five address pins are pulled-down strap inputs during reset.
// - all-low straps mean normal mode, 8-bit boot memory on select zero, buffers off.
// - strap pulldowns turn off when reset ends and stay off in normal operation.
// - each of the four straps sampled low regains its pulldown in suspend.
// - each of the four straps sampled high floats in suspend with no pulldown.
// - the reserved test strap always floats with pulldown in suspend.
// - boot memory strobes in suspend: drive high, float, or float with pulldown.
module memory_pin_suspend_state_control #(
  parameter ADDR_WIDTH = 13,
  parameter DATA_WIDTH = 16
) (
  // clock and reset
  input  wire                  clk_sys,
  input  wire                  rst,
  // power mode and configuration
  input  wire                  suspendMode,
  input  wire [1:0]            dramSuspendMode,
  input  wire [1:0]            romSuspendMode,
  input  wire [1:0]            upperBankEnable,
  // core dram controller levels
  input  wire [3:0]            rowStrobeCore,
  input  wire [3:0]            columnStrobeHighCore,
  input  wire [3:0]            columnStrobeLowCore,
  input  wire                  dramWriteCore,
  input  wire [ADDR_WIDTH-1:0] addrCore,
  input  wire                  dataDriveCore,
  // core refresh strobe levels used in suspend
  input  wire [3:0]            refreshRowStrobe,
  input  wire [3:0]            refreshColumnStrobe,
  // core boot memory strobes
  input  wire                  bootSel0Core,
  input  wire                  bootSel1Core,
  input  wire                  bootReadCore,
  input  wire                  bootWriteCore,
  // matrix scan function on shared pins
  input  wire [3:0]            scanLineOut,
  input  wire [3:0]            scanLineOeN,
  // strap pads
  input  wire [4:0]            strapPadIn,
  // dram strobe pads (bit0..3: banks)
  output reg  [3:0]            rowStrobeOut,
  output reg  [3:0]            rowStrobeOeN,
  output reg  [3:0]            rowStrobePullDown,
  output reg  [3:0]            columnStrobeHighByteOut,
  output reg  [3:0]            columnStrobeHighByteOeN,
  output reg  [3:0]            columnStrobeHighByteDn,
  output reg  [3:0]            columnStrobeLowByteOut,
  output reg  [3:0]            columnStrobeLowByteOeN,
  output reg  [3:0]            columnStrobeLowByteDn,
  // write strobe pad
  output reg                   dramWriteStrobeOut,
  output reg                   dramWriteStrobeOeN,
  output reg                   dramWriteStrobePullDown,
  // address pads
  output reg  [ADDR_WIDTH-1:0] addrOut,
  output reg  [ADDR_WIDTH-1:0] addrOeN,
  output reg  [ADDR_WIDTH-1:0] addrPullDown,
  // data pad pulldowns
  output wire [DATA_WIDTH-1:0] dataPullDown,
  // boot memory pads: select0, select1, read, write
  output wire [3:0]            bootStrobeOut,
  output wire [3:0]            bootStrobeOeN,
  output wire [3:0]            bootStrobePullDown,
  // decoded straps
  output wire [4:0]            strapValue,
  output wire                  testModeSel,
  output wire                  bootWide16,
  output wire                  dataBufferCtlEn
);

  // ****************************************
  // strap capture and decode
  // ****************************************
  wire [4:0] straps;
  wire [3:0] coreBoot;
  wire       suspend;
  integer    i;

  strap_latch #(
    .WIDTH (`STRAP_WIDTH)
  ) u_strap (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .strapPadIn   (strapPadIn),
    .strapValue_r (straps)
  );

  // all-low straps decode to the safe default; test strap must stay low on board
  assign strapValue      = straps;
  assign testModeSel     = straps[`STRAP_TEST_POS];
  assign bootWide16      = straps[1];
  assign dataBufferCtlEn = straps[3];

  // reset overrides suspend so reset pad states always win
  assign suspend = suspendMode & ~rst;

  // ****************************************
  // dram strobe pads
  // ****************************************
  // a strobe pad in suspend, by refresh option; reset holds it high
  function [2:0] strobePad; // {out, oeN, pulldown}
    input       inRst;
    input       inSus;
    input [1:0] mode;
    input       coreLvl;
    input       refLvl;
    begin
      if (inRst) begin
        strobePad = 3'h4;
      end else if (!inSus) begin
        strobePad = {coreLvl, 2'b00};
      end else begin
        case (mode)
          `DRAM_SUS_STROBE_REFRESH: strobePad = {refLvl, 2'b00};
          `DRAM_SUS_SELF_REFRESH:   strobePad = 3'h0;
          `DRAM_SUS_POWER_DOWN:     strobePad = 3'h3;
          default:                  strobePad = 3'h0;
        endcase
      end
    end
  endfunction

  reg [2:0] rp;
  reg [2:0] hp;
  reg [2:0] lp;
  reg       bankOwned;

  // banks 2..3 sit on scan-line pins and only follow dram when enabled
  always @* begin
    rowStrobeOut            = 4'h0;
    rowStrobeOeN            = 4'h0;
    rowStrobePullDown       = 4'h0;
    columnStrobeHighByteOut = 4'h0;
    columnStrobeHighByteOeN = 4'h0;
    columnStrobeHighByteDn  = 4'h0;
    columnStrobeLowByteOut  = 4'h0;
    columnStrobeLowByteOeN  = 4'h0;
    columnStrobeLowByteDn   = 4'h0;
    rp = 3'h0;
    hp = 3'h0;
    lp = 3'h0;
    bankOwned = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      // bit 0 of the index picks the enable, so no negative index is ever formed
      bankOwned = (i < 2) ? 1'b1 : upperBankEnable[i[0]];
      rp = strobePad(rst, suspend, dramSuspendMode, rowStrobeCore[i], refreshRowStrobe[i]);
      hp = strobePad(rst, suspend, dramSuspendMode, columnStrobeHighCore[i],
                     refreshColumnStrobe[i]);
      lp = strobePad(rst, suspend, dramSuspendMode, columnStrobeLowCore[i],
                     refreshColumnStrobe[i]);
      if (!bankOwned) begin
        // other function governs the pin
        rp = {scanLineOut[i], scanLineOeN[i], 1'b0};
        hp = {scanLineOut[i], scanLineOeN[i], 1'b0};
        lp = {scanLineOut[i], scanLineOeN[i], 1'b0};
      end
      rowStrobeOut[i]            = rp[2];
      rowStrobeOeN[i]            = rp[1];
      rowStrobePullDown[i]       = rp[0];
      columnStrobeHighByteOut[i] = hp[2];
      columnStrobeHighByteOeN[i] = hp[1];
      columnStrobeHighByteDn[i]  = hp[0];
      columnStrobeLowByteOut[i]  = lp[2];
      columnStrobeLowByteOeN[i]  = lp[1];
      columnStrobeLowByteDn[i]   = lp[0];
    end
  end

  // ****************************************
  // write strobe pad
  // ****************************************
  always @* begin
    dramWriteStrobeOut      = dramWriteCore;
    dramWriteStrobeOeN      = 1'b0;
    dramWriteStrobePullDown = 1'b0;
    if (rst) begin
      dramWriteStrobeOut = 1'b1;
    end else if (suspend) begin
      if (dramSuspendMode == `DRAM_SUS_POWER_DOWN) begin
        dramWriteStrobeOut      = 1'b0;
        dramWriteStrobeOeN      = 1'b1;
        dramWriteStrobePullDown = 1'b1;
      end else begin
        dramWriteStrobeOut = 1'b1;
      end
    end
  end

  // ****************************************
  // address pads
  // ****************************************
  // low five are straps; the rest float with pulldown in suspend
  always @* begin
    addrOut      = addrCore;
    addrOeN      = {ADDR_WIDTH{1'b0}};
    addrPullDown = {ADDR_WIDTH{1'b0}};
    if (rst) begin
      addrOut           = {ADDR_WIDTH{1'b0}};
      addrOeN[4:0]      = 5'h1F;
      addrPullDown[4:0] = 5'h1F;
    end else if (suspend) begin
      addrOut = {ADDR_WIDTH{1'b0}};
      addrOeN = {ADDR_WIDTH{1'b1}};
      addrPullDown = {ADDR_WIDTH{1'b1}};
      // a strap held high by the board must not fight a pulldown
      addrPullDown[3:0] = ~straps[3:0];
    end
  end

  // ****************************************
  // data and boot memory pads
  // ****************************************
  // reset and suspend both leave the data lines as inputs
  assign dataPullDown = {DATA_WIDTH{rst | suspend | ~dataDriveCore}};

  assign coreBoot = rst ? 4'hF : {bootWriteCore, bootReadCore, bootSel1Core, bootSel0Core};

  // one selector per boot strobe pad
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gBoot
      pad_mode_sel u_sel (
        .suspendActive  (suspend),
        .romSuspendMode (romSuspendMode),
        .normalLevel    (coreBoot[g]),
        .padOut         (bootStrobeOut[g]),
        .padOeN         (bootStrobeOeN[g]),
        .padPullDown    (bootStrobePullDown[g])
      );
    end
  endgenerate

endmodule // memory_pin_suspend_state_control

// ### shared/mem_pad_regs.vh
`ifndef MEM_PAD_REGS_VH
`define MEM_PAD_REGS_VH
// dram suspend refresh modes
`define DRAM_SUS_STROBE_REFRESH 2'h0
`define DRAM_SUS_SELF_REFRESH   2'h1
`define DRAM_SUS_POWER_DOWN     2'h2
// boot memory suspend options
`define ROM_SUS_DRIVE_HIGH      2'h0
`define ROM_SUS_FLOAT           2'h1
`define ROM_SUS_FLOAT_PULLDOWN  2'h2
// strap field positions in the latched strap word
`define STRAP_TEST_POS          4
`define STRAP_WIDTH             5
// reset values
`define STRAP_RESET_VALUE       5'h00
`define BANK_ENABLE_RESET       2'h0
`endif

// ### src/strap_latch.v
`timescale 1ns/10ps
`include "mem_pad_regs.vh"

// ****************************************
// strap capture
// ****************************************
module strap_latch #(
  parameter WIDTH = `STRAP_WIDTH
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  // pad inputs
  input  wire [WIDTH-1:0] strapPadIn,
  // captured straps
  output reg  [WIDTH-1:0] strapValue_r
);

  reg [WIDTH-1:0] syncA_r;
  reg [WIDTH-1:0] syncB_r;

  // two-stage sync; value follows the pad all through reset so the last
  // sample before release is the one kept
  always @(posedge clk_sys) begin
    syncA_r <= strapPadIn;
    syncB_r <= syncA_r;
    if (rst) begin
      strapValue_r <= syncB_r;
    end
  end

endmodule // strap_latch

// ### src/pad_mode_sel.v
`timescale 1ns/10ps
`include "mem_pad_regs.vh"

// ****************************************
// three-option suspend pad selector
// ****************************************
module pad_mode_sel (
  // controls
  input  wire       suspendActive,
  input  wire [1:0] romSuspendMode,
  input  wire       normalLevel,
  // pad controls
  output reg        padOut,
  output reg        padOeN,
  output reg        padPullDown
);

  // drive high, float, or float with pulldown while suspended
  always @* begin
    padOut      = normalLevel;
    padOeN      = 1'b0;
    padPullDown = 1'b0;
    if (suspendActive) begin
      case (romSuspendMode)
        `ROM_SUS_DRIVE_HIGH: begin
          padOut = 1'b1;
        end
        `ROM_SUS_FLOAT: begin
          padOeN = 1'b1;
        end
        `ROM_SUS_FLOAT_PULLDOWN: begin
          padOeN      = 1'b1;
          padPullDown = 1'b1;
        end
        default: begin
          padOut = 1'b1;
        end
      endcase
    end
  end

endmodule // pad_mode_sel

// ### verification/mem_pad_chk.sv
`timescale 1ns/10ps
`include "mem_pad_regs.vh"
// ****
// pad state checks
// ****
module mem_pad_chk #(
  parameter ADDR_WIDTH = 13,
  parameter DATA_WIDTH = 16
) (
  // clock and reset
  input wire                  clk_sys,
  input wire                  rst,
  // controls
  input wire                  suspendMode,
  input wire [1:0]            dramSuspendMode,
  input wire [1:0]            romSuspendMode,
  input wire                  dataDriveCore,
  input wire [3:0]            refreshRowStrobe,
  // pads
  input wire [3:0]            rowStrobeOut,
  input wire [3:0]            rowStrobeOeN,
  input wire [3:0]            rowStrobePullDown,
  input wire                  dramWriteStrobeOut,
  input wire                  dramWriteStrobeOeN,
  input wire                  dramWriteStrobePullDown,
  input wire [ADDR_WIDTH-1:0] addrOeN,
  input wire [ADDR_WIDTH-1:0] addrPullDown,
  input wire [DATA_WIDTH-1:0] dataPullDown,
  input wire [3:0]            bootStrobeOeN,
  input wire [3:0]            bootStrobePullDown,
  input wire [4:0]            strapValue
);
  // pads are combinational, so each relation holds in the very cycle of its cause
  default clocking cb @(posedge clk_sys); endclocking
  // the release edge still samples reset pad states, so checks wait one more edge
  reg rstSeen_r = 1'b1;
  always @(posedge clk_sys) rstSeen_r <= rst;
  default disable iff (rst || rstSeen_r);
  strobe_refresh_a: assert property (
    suspendMode && dramSuspendMode == `DRAM_SUS_STROBE_REFRESH |->
    rowStrobeOut[1:0] == refreshRowStrobe[1:0] && rowStrobeOeN[1:0] == 2'h0)
    else $error("row strobes not refreshing");
  self_refresh_a: assert property (
    suspendMode && dramSuspendMode == `DRAM_SUS_SELF_REFRESH |->
    rowStrobeOut[1:0] == 2'h0 && rowStrobeOeN[1:0] == 2'h0) else $error("row strobes not low");
  power_down_a: assert property (
    suspendMode && dramSuspendMode == `DRAM_SUS_POWER_DOWN |->
    {rowStrobeOeN[1:0], rowStrobePullDown[1:0]} == 4'hF &&
    {dramWriteStrobeOeN, dramWriteStrobePullDown} == 2'h3)
    else $error("dram pads not floated with pulldown");
  write_high_a: assert property (
    suspendMode && dramSuspendMode != `DRAM_SUS_POWER_DOWN |->
    dramWriteStrobeOut && !dramWriteStrobeOeN) else $error("write strobe not driven high");
  data_pull_a: assert property (
    !suspendMode |->
    dataPullDown == {DATA_WIDTH{!dataDriveCore}}) else $error("data pulldowns wrong");
  top_addr_a: assert property (
    suspendMode |->
    addrOeN[ADDR_WIDTH-1] && addrPullDown[ADDR_WIDTH-1]) else $error("top address not floated");
  strap_normal_a: assert property (
    !suspendMode |->
    addrPullDown[4:0] == 5'h00 && addrOeN[4:0] == 5'h00) else $error("strap pins not driven");
  strap_suspend_a: assert property (
    suspendMode |->
    addrOeN[4:0] == 5'h1F && addrPullDown[4:0] == {1'b1, ~strapValue[3:0]})
    else $error("strap pulldowns wrong in suspend");
  boot_float_a: assert property (
    suspendMode && romSuspendMode == `ROM_SUS_FLOAT |->
    bootStrobeOeN == 4'hF && bootStrobePullDown == 4'h0) else $error("boot strobes not floated");
endmodule // mem_pad_chk

bind memory_pin_suspend_state_control mem_pad_chk #(.ADDR_WIDTH(ADDR_WIDTH),
  .DATA_WIDTH(DATA_WIDTH)) i_chk (.clk_sys(clk_sys), .rst(rst), .suspendMode(suspendMode),
  .dramSuspendMode(dramSuspendMode), .romSuspendMode(romSuspendMode),
  .dataDriveCore(dataDriveCore), .refreshRowStrobe(refreshRowStrobe),
  .rowStrobeOut(rowStrobeOut), .rowStrobeOeN(rowStrobeOeN), .rowStrobePullDown(rowStrobePullDown),
  .dramWriteStrobeOut(dramWriteStrobeOut), .dramWriteStrobeOeN(dramWriteStrobeOeN),
  .dramWriteStrobePullDown(dramWriteStrobePullDown), .addrOeN(addrOeN),
  .addrPullDown(addrPullDown), .dataPullDown(dataPullDown), .bootStrobeOeN(bootStrobeOeN),
  .bootStrobePullDown(bootStrobePullDown), .strapValue(strapValue));

// ### verification/ext_memory_board.sv
`timescale 1ns/10ps
// ****
// board straps on the low address pads
// ****
module ext_memory_board (
  // clock
  input  wire       clk_sys,
  // board pullups
  input  wire [4:0] pullUpMask,
  // address pads
  input  wire [4:0] addrOut,
  input  wire [4:0] addrOeN,
  input  wire [4:0] addrPullDown,
  // resolved levels
  output reg  [4:0] strapPadIn
);
  reg     [4:0] padLast_r;
  wire    [4:0] boardUp = {1'b0, pullUpMask[3:0]};
  integer       i;
  // board pullups overpower the weak on-chip pulldowns
  always @* begin
    for (i = 0; i < 5; i = i + 1) begin
      if (!addrOeN[i]) strapPadIn[i] = addrOut[i];
      else if (boardUp[i]) strapPadIn[i] = 1'b1;
      else if (addrPullDown[i]) strapPadIn[i] = 1'b0;
      else strapPadIn[i] = ~padLast_r[i]; // an unpulled float never holds its old level
    end
  end
  // last level seen
  always @(posedge clk_sys) padLast_r <= strapPadIn;
endmodule // ext_memory_board

// ### verification/testbench.sv
`timescale 1ns/10ps
`include "mem_pad_regs.vh"
// ****
// pad state testbench
// ****
module testbench;
  reg         clk_sys = 1'b0, rst = 1'b1, suspendMode = 1'b0, dramWriteCore = 1'b0;
  reg         dataDriveCore = 1'b0;
  reg  [1:0]  dramSuspendMode = 2'h0, romSuspendMode = 2'h0, upperBankEnable = 2'h3;
  reg  [3:0]  rowStrobeCore = 4'h5, columnStrobeHighCore = 4'hA, columnStrobeLowCore = 4'h3;
  reg  [3:0]  refreshRowStrobe = 4'h6, refreshColumnStrobe = 4'h9, bootLevels = 4'hA;
  reg  [3:0]  scanLineOut = 4'hC, scanLineOeN = 4'h4;
  reg  [4:0]  pullUpMask = 5'h00;
  reg  [12:0] addrCore = 13'h0000;
  wire [3:0]  rowOut, rowOeN, rowPd, chOut, chOeN, chPd, clOut, clOeN, clPd, btOut, btOeN, btPd;
  wire [12:0] adOut, adOeN, adPd;
  wire [15:0] dataPd;
  wire [4:0]  strapValue, strapPad;
  wire        wrOut, wrOeN, wrPd, testModeSel, bootWide16, dataBufferCtlEn;
  integer     bad_count = 0, cmp_count = 0, m;
  // 100 MHz
  always #5 clk_sys = ~clk_sys;
  memory_pin_suspend_state_control i_dut (.clk_sys(clk_sys), .rst(rst),
    .suspendMode(suspendMode), .dramSuspendMode(dramSuspendMode), .romSuspendMode(romSuspendMode),
    .upperBankEnable(upperBankEnable), .rowStrobeCore(rowStrobeCore),
    .columnStrobeHighCore(columnStrobeHighCore), .columnStrobeLowCore(columnStrobeLowCore),
    .dramWriteCore(dramWriteCore), .addrCore(addrCore), .dataDriveCore(dataDriveCore),
    .refreshRowStrobe(refreshRowStrobe), .refreshColumnStrobe(refreshColumnStrobe),
    .bootSel0Core(bootLevels[0]), .bootSel1Core(bootLevels[1]), .bootReadCore(bootLevels[2]),
    .bootWriteCore(bootLevels[3]), .scanLineOut(scanLineOut), .scanLineOeN(scanLineOeN),
    .strapPadIn(strapPad), .rowStrobeOut(rowOut), .rowStrobeOeN(rowOeN), .rowStrobePullDown(rowPd),
    .columnStrobeHighByteOut(chOut), .columnStrobeHighByteOeN(chOeN), .columnStrobeHighByteDn(chPd),
    .columnStrobeLowByteOut(clOut), .columnStrobeLowByteOeN(clOeN), .columnStrobeLowByteDn(clPd),
    .dramWriteStrobeOut(wrOut), .dramWriteStrobeOeN(wrOeN), .dramWriteStrobePullDown(wrPd),
    .addrOut(adOut), .addrOeN(adOeN), .addrPullDown(adPd), .dataPullDown(dataPd),
    .bootStrobeOut(btOut), .bootStrobeOeN(btOeN), .bootStrobePullDown(btPd),
    .strapValue(strapValue), .testModeSel(testModeSel), .bootWide16(bootWide16),
    .dataBufferCtlEn(dataBufferCtlEn));
  ext_memory_board i_board (.clk_sys(clk_sys), .pullUpMask(pullUpMask), .addrOut(adOut[4:0]),
    .addrOeN(adOeN[4:0]), .addrPullDown(adPd[4:0]), .strapPadIn(strapPad));
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
    end
  endtask
  // inputs move on the edge; pads are settled one ns later
  task step(input s, input [1:0] dm, input [1:0] rm);
    begin
      @(posedge clk_sys);
      suspendMode <= s;
      dramSuspendMode <= dm;
      romSuspendMode <= rm;
      #1;
    end
  endtask
  // six cycles of reset; suspend left on must not matter
  task do_reset(input [4:0] mask);
    begin
      @(posedge clk_sys);
      rst <= 1'b1;
      pullUpMask <= mask;
      repeat (5) @(posedge clk_sys);
      #1;
      chk({rowOut, btOut, btOeN, 3'h0, wrOut}, 16'hFF01);
      chk({adOut[12:5], 3'h0, adOeN[4:0]}, 16'h001F);
      chk(adPd[4:0], 5'h1F);
      @(posedge clk_sys);
      rst <= 1'b0;
      #1;
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // watchdog: the tests need well under 100 cycles
  initial begin
    #5000;
    bad_count = bad_count + 1;
    close_out;
  end
  // ****
  // tests
  // ****
  initial begin
    do_reset(5'h00);
    chk({strapValue, testModeSel, dataBufferCtlEn, bootWide16}, 8'h00);
    $display("test reset defaults done");
    @(posedge clk_sys);
    addrCore <= 13'h1ABC;
    dataDriveCore <= 1'b1;
    #1;
    chk({adOut, 3'h0}, {13'h1ABC, 3'h0});
    chk({rowOut, chOut, clOut, btOut}, 16'h5A3A);
    chk({adOeN[4:0], adPd[4:0]}, 10'h000);
    chk(dataPd, 16'h0000);
    @(posedge clk_sys);
    dataDriveCore <= 1'b0;
    #1;
    chk(dataPd, 16'hFFFF);
    $display("test normal pads done");
    for (m = 0; m < 3; m = m + 1) begin
      step(1'b1, m[1:0], `ROM_SUS_DRIVE_HIGH);
      chk({adOeN[12], adPd[12]}, 2'h3);
      chk({adOeN[4:0], adPd[4:0]}, 10'h3FF);
      chk({btOut, btOeN}, 8'hF0);
      if (m == 0) begin
        chk({rowOut, chOut, clOut}, 12'h699);
        // refresh level moves on the edge like every other input
        @(posedge clk_sys);
        refreshRowStrobe <= 4'h9;
        #1;
        chk(rowOut, 4'h9);
      end
      if (m == 1) chk({rowOut, chOut, clOut, rowOeN}, 16'h0000);
      if (m == 2) chk({rowOeN, rowPd, chPd, clOeN}, 16'hFFFF);
      if (m == 2) chk({wrOeN, wrPd}, 2'h3);
      else chk({wrOut, wrOeN}, 2'h2);
    end
    $display("test dram suspend modes done");
    for (m = 0; m < 4; m = m + 1) begin
      step(1'b1, `DRAM_SUS_SELF_REFRESH, m[1:0]);
      if (m == 1) chk({btOeN, btPd}, 8'hF0);
      else if (m == 2) chk({btOeN, btPd}, 8'hFF);
      else chk({btOut, btOeN}, 8'hF0);
    end
    // core asks to drive data while suspended: the lines stay inputs
    @(posedge clk_sys);
    upperBankEnable <= 2'h1;
    dataDriveCore <= 1'b1;
    #1;
    chk({rowOut[3:2], rowOeN[3:2]}, 4'h8);
    chk(dataPd, 16'hFFFF);
    $display("test boot and shared strobes done");
    do_reset(5'h1A);
    chk({strapValue, testModeSel, dataBufferCtlEn, bootWide16}, 8'h53);
    step(1'b0, `DRAM_SUS_POWER_DOWN, `ROM_SUS_FLOAT);
    chk(adPd[4:0], 5'h00);
    step(1'b1, `DRAM_SUS_POWER_DOWN, `ROM_SUS_FLOAT);
    chk({adOeN[4:0], adPd[4:0]}, {5'h1F, 5'h15});
    $display("test pulled-up straps done");
    close_out;
  end
endmodule // testbench
